/* bpp_sequencer.sv */
`timescale 1ns/10ps
// Overview of operation
// - Opcodes 88h/89h program page from buffer.
// - Standard mode: dummy, 13-bit page, 10 dummies.
// - Binary mode: two dummies, page, 9 dummies.
// - Chip select rise copies buffer; busy meanwhile.
// - Failed byte program sets error flag.
// - Opcodes 82h/85h program with automatic erase.
// - Standard mode: page then 10-bit column.
// - Binary mode: page then 9-bit column.
// - Data bytes stored from given column onward.
// - Buffer write pointer wraps at page end.
// - Erase page first, then program, busy throughout.
// - Erase or program failure sets error flag.
// - Opcode 02h uses buffer 1, column format.
// - Only received bytes are programmed.
// - Partial byte at chip select rise aborts.
// - Program time scales with byte count.
// - Binary mode address is contiguous 22 bits.
module bpp_fifo #(
  parameter int W = 18,
  parameter int D = 2
) (
  input logic clk,
  input logic resetn,
  input logic in_valid,
  output logic in_ready,
  input logic [W-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW-1:0] wp_inc = (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
  wire [AW-1:0] rp_inc = (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
  assign in_ready = cnt_r != (AW + 1)'(D);
  assign out_valid = cnt_r != '0;
  assign out_data = mem_r[rp_r];
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_inc;
      if (pop)
        rp_r <= rp_inc;
      cnt_r <= cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end
endmodule : bpp_fifo

module bpp_sequencer #(
  parameter int ERASE_TIME_NS = bpp_pkg::ERASE_PROG_TIME_NS,
  parameter int ERASE_CYC = ERASE_TIME_NS / bpp_pkg::CLK_NS
) (
  input logic clk,
  input logic resetn,
  input logic sck,
  input logic cs_n,
  input logic si,
  input logic binary_page_mode,
  input logic mem_verify_fail,
  input logic mem_wready,
  output logic ready_busy,
  output logic program_erase_error_flag,
  output logic mem_erase,
  output logic [12:0] page_number_bits,
  output logic mem_wvalid,
  output logic [9:0] mem_col,
  output logic [7:0] mem_wdata
);
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} bpp_state_t;
  localparam logic [23:0] ERASE_CNT = 24'((ERASE_CYC < 1) ? 1 : ERASE_CYC);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  function automatic logic [9:0] col_of(input logic [23:0] a, input logic bin,
                                        input logic [9:0] sz);
    logic [9:0] c;
    c = bin ? {1'b0, a[bpp_pkg::BIN_PAGE_LSB-1:0]} : a[bpp_pkg::COL_W-1:0];
    col_of = (c >= sz) ? c - sz : c;
  endfunction : col_of

  function automatic logic [9:0] ptr_inc(input logic [9:0] p, input logic [9:0] last);
    ptr_inc = (p == last) ? '0 : p + 10'h1;
  endfunction : ptr_inc

  logic [2:0] s1_r, s2_r, s3_r, lvl_r;
  logic [2:0] bit_r, bit_nxt;
  logic [1:0] hdr_r, hdr_nxt;
  logic dph_r, dph_nxt, ok_r, ok_nxt;
  logic [6:0] sh_r, sh_nxt;
  logic [7:0] op_r, op_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [9:0] wptr_r, wptr_nxt, nb_r, nb_nxt;
  bpp_state_t st_r, st_nxt;
  logic [23:0] tmr_r, tmr_nxt;
  logic [9:0] rptr_r, rptr_nxt, left_r, left_nxt;
  logic erase_nxt, ready_r, err_r, b2_r;
  logic [12:0] page_r;
  logic [7:0] buf1_r [bpp_pkg::BUF_DEPTH];
  logic [7:0] buf2_r [bpp_pkg::BUF_DEPTH];
  logic f_in_ready, f_out_valid;
  logic [bpp_pkg::FIFO_W-1:0] f_out;

  // Only the second and third stages are compared, so a metastable first stage is never read.
  wire [2:0] agree = s2_r ~^ s3_r;
  wire [2:0] lvl_nxt = (s3_r & agree) | (lvl_r & ~agree);
  wire sck_rise = lvl_nxt[bpp_pkg::IDX_SCK] & ~lvl_r[bpp_pkg::IDX_SCK];
  wire cs_fall = ~lvl_nxt[bpp_pkg::IDX_CS] & lvl_r[bpp_pkg::IDX_CS];
  wire cs_rise = lvl_nxt[bpp_pkg::IDX_CS] & ~lvl_r[bpp_pkg::IDX_CS];
  wire cs_low = ~lvl_r[bpp_pkg::IDX_CS];
  wire [7:0] byte_val = {sh_r, lvl_nxt[bpp_pkg::IDX_SI]};
  wire byte_done = sck_rise & cs_low & (bit_r == bpp_pkg::BIT_LAST);
  wire [9:0] page_sz = binary_page_mode ? bpp_pkg::BIN_PAGE : bpp_pkg::STD_PAGE;
  wire [9:0] page_last = page_sz - 10'h1;
  wire [23:0] addr_cat = {addr_r[15:0], byte_val};

  wire is_nerase = (op_r == bpp_pkg::OP_B1_NOERASE) | (op_r == bpp_pkg::OP_B2_NOERASE);
  wire is_auto = (op_r == bpp_pkg::OP_B1_AUTO) | (op_r == bpp_pkg::OP_B2_AUTO);
  wire is_byte = op_r == bpp_pkg::OP_B1_BYTE;
  wire is_thru = is_auto | is_byte;
  wire sel_b2 = (op_r == bpp_pkg::OP_B2_AUTO) | (op_r == bpp_pkg::OP_B2_NOERASE);
  wire abort = is_byte & (bit_r != '0);
  wire start = (st_r == ST_IDLE) & cs_rise & ok_r & dph_r & (is_thru | is_nerase) & ~abort;
  wire buf_we = byte_done & dph_r & ok_r & is_thru & ~cs_fall;

  // Standard mode skips one dummy bit, binary mode two; both give 13 page bits.
  wire [12:0] page_std = addr_r[bpp_pkg::STD_PAGE_LSB +: bpp_pkg::PAGE_W];
  wire [12:0] page_bin = addr_r[bpp_pkg::BIN_PAGE_LSB +: bpp_pkg::PAGE_W];
  // In binary mode page and column concatenate to one flat 22-bit byte address.
  wire [12:0] page_dec = binary_page_mode ? page_bin : page_std;
  wire [9:0] col_dec = col_of(addr_r, binary_page_mode, page_sz);

  wire prog = st_r == ST_PROG;
  wire f_in_valid = prog & (left_r != '0);
  wire push = f_in_valid & f_in_ready;
  wire [7:0] rd_byte = b2_r ? buf2_r[rptr_r] : buf1_r[rptr_r];
  wire drain_ok = prog & (tmr_r == '0);
  assign mem_wvalid = f_out_valid & drain_ok;
  wire wr_fire = mem_wvalid & mem_wready;
  wire erase_end = (st_r == ST_ERASE) & (tmr_r == 24'h1);
  wire err_set = (erase_end | wr_fire) & mem_verify_fail;

  always_comb
  begin
    bit_nxt = bit_r;
    hdr_nxt = hdr_r;
    dph_nxt = dph_r;
    sh_nxt = sh_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    wptr_nxt = wptr_r;
    nb_nxt = nb_r;
    ok_nxt = ok_r;
    if (cs_fall)
    begin
      bit_nxt = '0;
      hdr_nxt = '0;
      dph_nxt = 1'b0;
      nb_nxt = '0;
      // Frames opened while busy are ignored, so buffers stay intact during programming.
      ok_nxt = st_r == ST_IDLE;
    end
    else if (sck_rise && cs_low)
    begin
      sh_nxt = byte_val[6:0];
      bit_nxt = bit_r + 3'h1;
      if (byte_done && dph_r && buf_we)
      begin
        wptr_nxt = ptr_inc(wptr_r, page_last);
        if (nb_r != page_sz)
          nb_nxt = nb_r + 10'h1;
      end
      else if (byte_done && !dph_r)
      begin
        hdr_nxt = hdr_r + 2'h1;
        if (hdr_r == bpp_pkg::HDR_OP)
          op_nxt = byte_val;
        else
          addr_nxt = addr_cat;
        if (hdr_r == bpp_pkg::HDR_LAST)
        begin
          dph_nxt = 1'b1;
          wptr_nxt = col_of(addr_cat, binary_page_mode, page_sz);
        end
      end
    end
  end

  always_comb
  begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    rptr_nxt = rptr_r;
    left_nxt = left_r;
    erase_nxt = 1'b0;
    case (st_r)
      ST_IDLE:
        if (start)
        begin
          st_nxt = is_auto ? ST_ERASE : ST_PROG;
          tmr_nxt = is_auto ? ERASE_CNT : '0;
          erase_nxt = is_auto;
          rptr_nxt = is_byte ? col_dec : '0;
          left_nxt = is_byte ? nb_r : page_sz;
        end
      ST_ERASE:
      begin
        tmr_nxt = tmr_r - 24'h1;
        if (erase_end)
          st_nxt = ST_PROG;
      end
      ST_PROG:
      begin
        if (push)
        begin
          rptr_nxt = ptr_inc(rptr_r, page_last);
          left_nxt = left_r - 10'h1;
        end
        // Each accepted byte holds the array port off for one byte time.
        if (wr_fire)
          tmr_nxt = bpp_pkg::BYTE_CYC;
        else if (tmr_r != '0)
          tmr_nxt = tmr_r - 24'h1;
        if (left_r == '0 && !f_out_valid && tmr_r == '0)
          st_nxt = ST_IDLE;
      end
      default:
        st_nxt = ST_IDLE;
    endcase
  end

  bpp_fifo #(.W(bpp_pkg::FIFO_W), .D(bpp_pkg::FIFO_D)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data({rptr_r, rd_byte}),
    .out_valid(f_out_valid),
    .out_ready(mem_wready & drain_ok),
    .out_data(f_out)
  );
  assign mem_col = f_out[17:8];
  assign mem_wdata = f_out[7:0];
  assign ready_busy = ready_r;
  assign program_erase_error_flag = err_r;
  assign page_number_bits = page_r;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      {s1_r, s2_r, s3_r} <= {3{bpp_pkg::LVL_RST}};
      lvl_r <= bpp_pkg::LVL_RST;
      {bit_r, hdr_r, dph_r, ok_r, sh_r, op_r} <= '0;
      {addr_r, wptr_r, nb_r} <= '0;
    end
    else
    begin
      {s1_r, s2_r, s3_r} <= {{si, cs_n, sck}, s1_r, s2_r};
      lvl_r <= lvl_nxt;
      {bit_r, hdr_r, dph_r, ok_r, sh_r, op_r} <= {bit_nxt, hdr_nxt, dph_nxt, ok_nxt, sh_nxt, op_nxt};
      {addr_r, wptr_r, nb_r} <= {addr_nxt, wptr_nxt, nb_nxt};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_r <= ST_IDLE;
      {tmr_r, rptr_r, left_r, page_r, b2_r} <= '0;
      {mem_erase, ready_r, err_r} <= 3'h2;
    end
    else
    begin
      st_r <= st_nxt;
      {tmr_r, rptr_r, left_r} <= {tmr_nxt, rptr_nxt, left_nxt};
      mem_erase <= erase_nxt;
      ready_r <= st_nxt == ST_IDLE;
      // A failure in the cycle of a new start still wins over the clear.
      err_r <= err_set | (err_r & ~start);
      if (start)
      begin
        page_r <= page_dec;
        b2_r <= sel_b2 & ~is_byte;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (buf_we && !sel_b2)
      buf1_r[wptr_r] <= byte_val;
    if (buf_we && sel_b2)
      buf2_r[wptr_r] <= byte_val;
  end

  busy_on_start_a: assert property (start |=> !ready_busy [*2]) else $error("not busy");
  erase_first_a: assert property (start && is_auto |=> mem_erase) else $error("no erase");
  no_erase_a: assert property (start && !is_auto |=> !mem_erase) else $error("erase");
  abort_a: assert property (cs_rise && ok_r && dph_r && abort |=> ready_busy) else $error("abort");
  err_prog_a: assert property (wr_fire && mem_verify_fail |=> program_erase_error_flag)
    else $error("prog err lost");
  err_erase_a: assert property (erase_end && mem_verify_fail |=> program_erase_error_flag)
    else $error("erase err lost");
  byte_gap_a: assert property (wr_fire |=> !mem_wvalid [*8]) else $error("byte gap");
  wptr_wrap_a: assert property (buf_we && wptr_r == page_last |=> wptr_r == '0)
    else $error("no wrap");
  buf_sel_a: assert property (start && op_r == bpp_pkg::OP_B2_NOERASE |=> b2_r)
    else $error("buffer select");
  byte_cnt_a: assert property (start && is_byte |=> left_r == $past(nb_r))
    else $error("byte count");
  auto_c: cover property (start && is_auto);
  byte_c: cover property (start && is_byte);
  abort_c: cover property (cs_rise && ok_r && dph_r && abort);
  erase_prog_c: cover property (st_r == ST_ERASE ##1 st_r == ST_PROG);
endmodule : bpp_sequencer

/* bpp_pkg.sv */
package bpp_pkg;
  localparam logic [7:0] OP_B1_NOERASE = 8'h88;
  localparam logic [7:0] OP_B2_NOERASE = 8'h89;
  localparam logic [7:0] OP_B1_AUTO = 8'h82;
  localparam logic [7:0] OP_B2_AUTO = 8'h85;
  localparam logic [7:0] OP_B1_BYTE = 8'h02;
  localparam logic [9:0] STD_PAGE = 10'h210;
  localparam logic [9:0] BIN_PAGE = 10'h200;
  localparam int BUF_DEPTH = 528;
  localparam int PAGE_W = 13;
  localparam int COL_W = 10;
  localparam int ADDR_W = 24;
  localparam int STD_PAGE_LSB = 10;
  localparam int BIN_PAGE_LSB = 9;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] HDR_LAST = 2'h3;
  localparam logic [1:0] HDR_OP = 2'h0;
  localparam int IDX_SCK = 0;
  localparam int IDX_CS = 1;
  localparam int IDX_SI = 2;
  localparam logic [2:0] LVL_RST = 3'h2;
  localparam int CLK_NS = 40;
  localparam int BYTE_PROG_TIME_NS = 8000;
  localparam int BYTE_CYC_I = BYTE_PROG_TIME_NS / CLK_NS;
  localparam logic [23:0] BYTE_CYC = 24'((BYTE_CYC_I < 1) ? 1 : BYTE_CYC_I);
  localparam int ERASE_PROG_TIME_NS = 2000000;
  localparam int FIFO_W = 18;
  localparam int FIFO_D = 2;
endpackage : bpp_pkg

/* bpp_array_model.sv */
`timescale 1ns/10ps
module bpp_array_model (
  input wire logic clk,
  input wire logic mem_wvalid,
  input wire logic slow,
  input wire logic fail_en,
  output logic mem_wready,
  output logic mem_verify_fail
);
  logic [1:0] wait_r;
  // A slow array keeps each write waiting three cycles, so the buffer has to hold it.
  always_ff @(posedge clk)
  begin
    if (!mem_wvalid || mem_wready)
      wait_r <= 2'h0;
    else if (wait_r != 2'h3)
      wait_r <= wait_r + 2'h1;
  end
  assign mem_wready = mem_wvalid && (!slow || wait_r == 2'h3);
  assign mem_verify_fail = fail_en;
endmodule : bpp_array_model

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic clk, resetn, sck, cs_n, si, binary_page_mode, slow, fail_en;
  logic mem_verify_fail, mem_wready, ready_busy, program_erase_error_flag, mem_erase, mem_wvalid;
  logic [12:0] page_number_bits, pg;
  logic [9:0] mem_col;
  logic [7:0] mem_wdata, d0, d1, d2;
  logic [15:0] rnd;
  logic [31:0] exp_q[$];
  logic [31:0] seen;
  logic [7:0] ops [3] = '{8'h82, 8'h85, 8'h89};
  int err_count, n_tests;
  int cyc = 0;
  time last_t = 0;

  bpp_sequencer #(.ERASE_CYC(20)) u_bpp_sequencer (.clk(clk), .resetn(resetn), .sck(sck),
    .cs_n(cs_n), .si(si), .binary_page_mode(binary_page_mode), .mem_verify_fail(mem_verify_fail),
    .mem_wready(mem_wready), .ready_busy(ready_busy),
    .program_erase_error_flag(program_erase_error_flag), .mem_erase(mem_erase),
    .page_number_bits(page_number_bits), .mem_wvalid(mem_wvalid), .mem_col(mem_col),
    .mem_wdata(mem_wdata));
  bpp_array_model u_bpp_array_model (.clk(clk), .mem_wvalid(mem_wvalid), .slow(slow),
    .fail_en(fail_en), .mem_wready(mem_wready), .mem_verify_fail(mem_verify_fail));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [15:0] xs(input logic [15:0] v);
    logic [15:0] t;
    t = v ^ (v << 7);
    t = t ^ (t >> 9);
    return t ^ (t << 8);
  endfunction : xs

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  task automatic do_reset;
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
  endtask : do_reset

  // The serial clock idles low and only moves inside a frame.
  task automatic send(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      si = v[i];
      sck = 1'b0;
      repeat (4) @(negedge clk);
      sck = 1'b1;
      repeat (4) @(negedge clk);
    end
  endtask : send

  task automatic frame_start;
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
  endtask : frame_start

  task automatic frame_end;
    sck = 1'b0;
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    si = ~si;
    repeat (8) @(negedge clk);
  endtask : frame_end

  task automatic wait_rb(input logic v, input int lim);
    int k;
    k = 0;
    while (ready_busy !== v && k < lim)
    begin
      @(negedge clk);
      k++;
    end
    chk(32'(ready_busy), 32'(v));
  endtask : wait_rb

  task automatic drain(input int lim);
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < lim)
    begin
      @(negedge clk);
      k++;
    end
    chk(32'(exp_q.size()), 32'h0);
  endtask : drain

  // Every erase pulse and write handshake must match the oldest expected entry.
  always @(posedge clk)
  begin
    if (resetn && (mem_erase === 1'b1 || (mem_wvalid && mem_wready) === 1'b1))
    begin
      seen = mem_erase ? {1'b1, page_number_bits, 18'h0} :
        {1'b0, page_number_bits, mem_col, mem_wdata};
      if (exp_q.size() == 0)
        chk(seen, 32'hFFFFFFFF);
      else
        chk(seen, exp_q.pop_front());
      if (!mem_erase && last_t != 0)
        chk(32'(($time - last_t) >= bpp_pkg::BYTE_PROG_TIME_NS), 32'h1);
      last_t = mem_erase ? 0 : $time;
    end
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_count++;
      results;
    end
  end

  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    binary_page_mode = 1'b0;
    slow = 1'b1;
    fail_en = 1'b1;
    rnd = 16'h84EC;
    err_count = 0;
    n_tests = 0;
    do_reset;
    chk(32'({ready_busy, program_erase_error_flag}), 32'h2);
    rnd = xs(rnd);
    pg = rnd[12:0];
    rnd = xs(rnd);
    d0 = rnd[7:0];
    d1 = rnd[15:8];
    rnd = xs(rnd);
    d2 = rnd[7:0];
    exp_q.push_back({1'b0, pg, 10'h20E, d0});
    exp_q.push_back({1'b0, pg, 10'h20F, d1});
    exp_q.push_back({1'b0, pg, 10'h000, d2});
    frame_start;
    send({8'h02, 1'b0, pg, 10'h20E}, 32);
    send({8'h00, d0, d1, d2}, 24);
    frame_end;
    wait_rb(1'b0, 8);
    drain(2000);
    wait_rb(1'b1, 400);
    chk(32'(program_erase_error_flag), 32'h1);
    $display("done byte program with wrap");
    fail_en = 1'b0;
    frame_start;
    send({8'h02, 1'b0, pg, 10'h000}, 32);
    send(32'h5A5, 11);
    frame_end;
    repeat (40) @(negedge clk);
    chk(32'(ready_busy), 32'h1);
    $display("done partial byte abort");
    binary_page_mode = 1'b1;
    rnd = xs(rnd);
    pg = rnd[12:0];
    // The aborted frame still loaded its one whole byte into buffer 1; only programming is dropped.
    exp_q.push_back({1'b0, pg, 10'h000, 8'hB4});
    frame_start;
    send({8'h88, 2'b00, pg, 9'h000}, 32);
    frame_end;
    wait_rb(1'b0, 8);
    chk(32'(program_erase_error_flag), 32'h0);
    drain(400);
    // A whole page would outlast the run, so each page test stops after its first byte.
    chk(32'(ready_busy), 32'h0);
    do_reset;
    $display("done binary program from buffer");
    binary_page_mode = 1'b0;
    foreach (ops[i])
    begin
      // A plain program reuses the page that the auto-erase before it has just cleared.
      if (ops[i] != 8'h89)
      begin
        rnd = xs(rnd);
        pg = rnd[12:0];
        d0 = rnd[15:8];
        exp_q.push_back({1'b1, pg, 18'h0});
      end
      exp_q.push_back({1'b0, pg, 10'h000, d0});
      fail_en = (i == 0);
      frame_start;
      send({ops[i], 1'b0, pg, 10'h000}, 32);
      if (ops[i] != 8'h89)
        send(32'(d0), 8);
      frame_end;
      drain(600);
      chk(32'(ready_busy), 32'h0);
      chk(32'(program_erase_error_flag), 32'(i == 0));
      do_reset;
      $display("done opcode %h", ops[i]);
    end
    results;
  end
endmodule : testbench
